//--- core/csh_consts.svh
// Constants for the clocked serial handshake block
`ifndef CSH_CONSTS_SVH
`define CSH_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Least start hold, in tenths of a transfer-clock cycle
`define CSH_START_HOLD_TENTHS 15
// Least hold rounded up to whole transfer-clock cycles
`define CSH_START_HOLD_CYC    ((`CSH_START_HOLD_TENTHS + 9) / 10)

// ----------------------------------------------------------------
// Unit sizes and reset values
// ----------------------------------------------------------------
`define CSH_UNIT_TOP_8  8'h07
`define CSH_PINS_RST    8'h66
`define CSH_LSYNC_RST   12'h002
`define CSH_SSYNC_RST   1'h0

`endif

//--- core/csh_pkg.sv
// Types for the clocked serial handshake block
package csh_pkg;

    // ------------------------------------------------------------
    // Configuration and pins
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CSH_MODE_8BIT,
        CSH_MODE_ARB,
        CSH_MODE_AUTO
    } csh_mode_t;

    typedef struct packed {
        logic      init_en;
        logic      int_clk;
        csh_mode_t mode;
        logic      func_whole;
        logic      sout_hiz;
        logic      busy_in_used;
        logic      ready_in_used;
        logic      busy_out_used;
    } csh_cfg_t;

    typedef struct packed {
        logic transfer_end_strobe;
        logic transfer_end_strobe_n;
        logic busy_handshake;
        logic busy_handshake_n;
        logic ready_handshake;
        logic ready_handshake_n;
        logic serial_data_out_oe_n;
        logic serial_clock_pin_en;
    } csh_pins_t;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CSH_IDLE,
        CSH_ARM,
        CSH_LEAD,
        CSH_SHIFT,
        CSH_STB,
        CSH_TAIL
    } csh_lst_t;

    typedef struct packed {
        csh_lst_t  st;
        logic [7:0] bits;
        logic [7:0] top;
        logic [7:0] units;
        logic [1:0] hold;
        logic       fin;
        logic       start_prev;
        logic       done_tgl;
        csh_pins_t  pins;
    } csh_link_t;

    typedef struct packed {
        logic       flag;
        logic       irq;
        logic       start_tgl;
        logic       done_prev;
        logic [7:0] count;
    } csh_sys_t;

endpackage : csh_pkg

//--- core/csh_sync.sv
// Two-stage level synchroniser
`timescale 1ns/100ps
module csh_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    // First stage feeds only the second, never other logic
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : csh_sync

//--- core/csh_handshake.sv
// Handshake logic of a clocked synchronous serial port
//
// Contract
// - Transfer-end strobe only with internal clock, never with external clock.
// - Initialization bit low holds strobe low, complement high.
// - Strobe pulses high one transfer-clock cycle after last bit, then idles.
// - Completion toggles one transfer-clock cycle after the strobe ends; the status flag clears three ref edges later.
// - Auto mode function bit picks strobe per byte or once at end.
// - Internal clock: busy input going high mid-unit does not stop the current unit.
// - Unit is 8 bits, or counter plus one bits in arbitrary mode.
// - External clock edges are ignored while busy input is high.
// - With high-impedance option, data output drives only while busy input low.
// - Initialization bit low holds busy output high, complement low.
// - Auto mode function bit picks busy per byte or whole transfer.
// - Internal clock: busy output falls one transfer-clock cycle before first clock.
// - Whole-transfer auto mode: busy output falls on first data write.
// - External clock: busy output falls on the starting data write.
// - Busy output returns idle with the completion toggle, before the status flag clears.
// - Per-byte auto mode: busy output rises after each received byte.
// - Ready output idles low, rises on write, falls at first clock.
// - Ready input honoured only when ready input and busy output used.
// - External clock: busy output asserts only with ready high and data written.
// - Status flag sets on starting write, clears with interrupt at completion.
`timescale 1ns/100ps
`include "csh_consts.svh"
module csh_handshake (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               link_clk,
    input  wire csh_pkg::csh_cfg_t  cfg,
    input  wire logic               wr_sreg,
    input  wire logic [7:0]         wr_data,
    input  wire logic               busy_handshake_in,
    input  wire logic               ready_handshake_in,
    output logic                    xfer_flag,
    output logic                    xfer_irq,
    output csh_pkg::csh_pins_t      pins
);
    import csh_pkg::*;

    localparam logic [1:0] HOLD_LAST = 2'(`CSH_START_HOLD_CYC - 1);

    // ------------------------------------------------------------
    // Crossings
    // ------------------------------------------------------------
    csh_sys_t   s_q;
    csh_sys_t   s_d;
    csh_link_t  l_q;
    csh_link_t  l_d;
    logic [11:0] lsync_q;
    csh_cfg_t   lcfg;
    logic       l_start;
    logic       l_busy;
    logic       l_ready;
    logic       s_done;

    // Pins and sys levels are sampled on the transfer clock
    csh_sync #(
        .W       (12),
        .RST_VAL (`CSH_LSYNC_RST)
    ) u_lsync (
        .clk   (link_clk),
        .rst_n (rst_n),
        .d     ({cfg, s_q.start_tgl, busy_handshake_in, ready_handshake_in}),
        .q     (lsync_q)
    );

    assign {lcfg, l_start, l_busy, l_ready} = lsync_q;

    csh_sync #(
        .W       (1),
        .RST_VAL (`CSH_SSYNC_RST)
    ) u_ssync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     (l_q.done_tgl),
        .q     (s_done)
    );

    // ------------------------------------------------------------
    // System side
    // ------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.irq       = 1'b0;
        s_d.done_prev = s_done;
        if (s_done ^ s_q.done_prev) begin
            s_d.flag = 1'b0;
            s_d.irq  = 1'b1;
        end
        // Set after clear: a write in the completion cycle is kept
        if (wr_sreg & cfg.init_en) begin
            s_d.flag      = 1'b1;
            s_d.count     = wr_data;
            s_d.start_tgl = ~s_q.start_tgl;
        end
        if (!cfg.init_en) begin
            s_d.flag = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign xfer_flag = s_q.flag;
    assign xfer_irq  = s_q.irq;

    // ------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------
    logic start_ev;
    logic per_byte;
    logic whole;
    logic rdy_hon;
    logic busy_ok;
    logic hs_ok;
    logic unit_end;
    logic last;
    logic adv;

    always_comb begin
        l_d            = l_q;
        l_d.start_prev = l_start;
        start_ev       = l_start ^ l_q.start_prev;
        per_byte       = (lcfg.mode == CSH_MODE_AUTO) & ~lcfg.func_whole;
        whole          = (lcfg.mode == CSH_MODE_AUTO) & lcfg.func_whole;
        rdy_hon        = lcfg.ready_in_used & lcfg.busy_out_used;
        busy_ok        = ~lcfg.busy_in_used | ~l_busy;
        hs_ok          = busy_ok & (~rdy_hon | l_ready);
        unit_end       = (l_q.bits == l_q.top);
        last           = (lcfg.mode != CSH_MODE_AUTO) | (l_q.units == 8'h00);
        // External edges count only while the busy input is low
        adv            = lcfg.int_clk | busy_ok;
        unique case (l_q.st)
            CSH_IDLE: begin
                if (start_ev) begin
                    // Count is stable here: it was written in the same ref edge as the toggle
                    l_d.bits                 = 8'h00;
                    l_d.hold                 = 2'h0;
                    l_d.fin                  = 1'b0;
                    l_d.st                   = CSH_ARM;
                    l_d.pins.ready_handshake = 1'b1;
                    if (lcfg.mode == CSH_MODE_ARB) begin
                        l_d.top = s_q.count;
                    end else begin
                        l_d.top = `CSH_UNIT_TOP_8;
                    end
                    if (lcfg.mode == CSH_MODE_AUTO) begin
                        l_d.units = s_q.count;
                    end else begin
                        l_d.units = 8'h00;
                    end
                    if (whole & lcfg.int_clk) begin
                        l_d.pins.busy_handshake = 1'b0;
                    end
                end
            end
            CSH_ARM: begin
                if (lcfg.int_clk) begin
                    if (hs_ok) begin
                        if (l_q.hold == HOLD_LAST) begin
                            // One cycle of lead before the first clock
                            l_d.pins.busy_handshake = 1'b0;
                            l_d.st                  = CSH_LEAD;
                        end else begin
                            l_d.hold = l_q.hold + 2'h1;
                        end
                    end else begin
                        l_d.hold = 2'h0;
                    end
                end else if (~rdy_hon | l_ready) begin
                    l_d.pins.busy_handshake = 1'b0;
                    l_d.st                  = CSH_SHIFT;
                end
            end
            CSH_LEAD: begin
                l_d.pins.serial_clock_pin_en = 1'b1;
                l_d.st                       = CSH_SHIFT;
            end
            CSH_SHIFT: begin
                if (adv) begin
                    l_d.pins.ready_handshake = 1'b0;
                    l_d.bits                 = l_q.bits + 8'h01;
                    // With internal clock the handshake inputs cannot stop the unit; only the initialization bit can
                    if (unit_end) begin
                        l_d.bits = 8'h00;
                        l_d.fin  = last;
                        if (!last) begin
                            l_d.units = l_q.units - 8'h01;
                        end
                        if (per_byte) begin
                            l_d.pins.busy_handshake = 1'b1;
                        end
                        if (lcfg.int_clk & (per_byte | last)) begin
                            l_d.pins.transfer_end_strobe = 1'b1;
                            l_d.pins.serial_clock_pin_en = 1'b0;
                            l_d.st                       = CSH_STB;
                        end else if (last) begin
                            l_d.pins.serial_clock_pin_en = 1'b0;
                            l_d.st                       = CSH_TAIL;
                        end else if (per_byte) begin
                            l_d.pins.serial_clock_pin_en = 1'b0;
                            l_d.hold                     = 2'h0;
                            l_d.st                       = CSH_ARM;
                        end
                    end
                end
            end
            CSH_STB: begin
                l_d.pins.transfer_end_strobe = 1'b0;
                l_d.hold                     = 2'h0;
                if (l_q.fin) begin
                    l_d.st = CSH_TAIL;
                end else begin
                    l_d.st = CSH_ARM;
                end
            end
            CSH_TAIL: begin
                // Flag clears in the sys domain three ref edges after the toggle
                l_d.pins.busy_handshake = 1'b1;
                l_d.done_tgl            = ~l_q.done_tgl;
                l_d.st                  = CSH_IDLE;
            end
            default: begin
                l_d.st = CSH_IDLE;
            end
        endcase
        if (!lcfg.init_en) begin
            l_d.st                       = CSH_IDLE;
            l_d.pins.transfer_end_strobe = 1'b0;
            l_d.pins.busy_handshake      = 1'b1;
            l_d.pins.ready_handshake     = 1'b0;
            l_d.pins.serial_clock_pin_en = 1'b0;
        end
        if (!lcfg.int_clk) begin
            l_d.pins.transfer_end_strobe = 1'b0;
        end
        l_d.pins.serial_data_out_oe_n  = lcfg.sout_hiz & l_busy;
        l_d.pins.transfer_end_strobe_n = ~l_d.pins.transfer_end_strobe;
        l_d.pins.busy_handshake_n      = ~l_d.pins.busy_handshake;
        l_d.pins.ready_handshake_n     = ~l_d.pins.ready_handshake;
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            l_q      <= '0;
            l_q.st   <= CSH_IDLE;
            l_q.pins <= `CSH_PINS_RST;
        end else begin
            l_q <= l_d;
        end
    end

    assign pins = l_q.pins;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_STB_INT: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        l_q.pins.transfer_end_strobe |-> $past(lcfg.int_clk))
        else $error("Strobe with external clock");

    AST_STB_INIT: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        !lcfg.init_en |=> !l_q.pins.transfer_end_strobe)
        else $error("Strobe active while not initialised");

    AST_STB_ONE: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        $rose(l_q.pins.transfer_end_strobe) |=> !l_q.pins.transfer_end_strobe)
        else $error("Strobe longer than one cycle");

    AST_DONE_AFTER_STB: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        $fell(l_q.pins.transfer_end_strobe) && l_q.st == CSH_TAIL
        |=> l_q.done_tgl != $past(l_q.done_tgl))
        else $error("Done not signalled one cycle after strobe");

    AST_UNIT_8: assert property (
        @(posedge link_clk) disable iff (!rst_n || !lcfg.init_en)
        $rose(l_q.pins.serial_clock_pin_en) && lcfg.int_clk
        && lcfg.mode == CSH_MODE_8BIT
        |-> l_q.pins.serial_clock_pin_en [*8] ##1 !l_q.pins.serial_clock_pin_en)
        else $error("Clock burst not eight cycles");

    AST_EXT_HOLD: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        l_q.st == CSH_SHIFT && !lcfg.int_clk && lcfg.busy_in_used && l_busy
        && lcfg.init_en |=> l_q.bits == $past(l_q.bits))
        else $error("Shift on edge while busy input high");

    AST_OE: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        lcfg.sout_hiz && l_busy |=> l_q.pins.serial_data_out_oe_n)
        else $error("Data output driven while busy input high");

    AST_BUSY_INIT: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        !lcfg.init_en |=> l_q.pins.busy_handshake)
        else $error("Busy output active while not initialised");

    AST_LEAD: assert property (
        @(posedge link_clk) disable iff (!rst_n || !lcfg.init_en)
        l_q.st == CSH_LEAD |-> !l_q.pins.busy_handshake
        ##1 l_q.pins.serial_clock_pin_en)
        else $error("No clock one cycle after busy lead");

    AST_BUSY_END: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        l_q.st == CSH_TAIL |=> l_q.pins.busy_handshake)
        else $error("Busy output not idle at end");

    AST_RDY_FALL: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        l_q.st == CSH_SHIFT && adv |=> !l_q.pins.ready_handshake)
        else $error("Ready output high after first clock");

    AST_COMP: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        l_q.pins.busy_handshake_n == !l_q.pins.busy_handshake
        && l_q.pins.ready_handshake_n == !l_q.pins.ready_handshake
        && l_q.pins.transfer_end_strobe_n == !l_q.pins.transfer_end_strobe)
        else $error("Complement pin mismatch");

    AST_FLAG_SET: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_sreg && cfg.init_en |=> s_q.flag)
        else $error("Flag not set by write");

    AST_FLAG_IRQ: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(s_q.flag) && $past(cfg.init_en) |-> s_q.irq)
        else $error("Flag cleared without interrupt");

endmodule : csh_handshake

//--- tb/csh_partner.sv
// Model of the serial transfer destination at the handshake inputs
`timescale 1ns/100ps
module csh_partner (
    input  wire logic       link_clk,
    input  wire logic       rst_n,
    input  wire logic       en,
    input  wire logic [3:0] lag,
    output logic            busy_handshake_in,
    output logic            ready_handshake_in
);
    logic [3:0] wait_q;

    // ------------------------------------------------------------
    // Handshake driver
    // ------------------------------------------------------------
    // Levels change just after the rising edge, so only while the clock is high
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q             <= 4'h0;
            busy_handshake_in  <= 1'b1;
            ready_handshake_in <= 1'b0;
        end else if (!en) begin
            wait_q             <= 4'h0;
            busy_handshake_in  <= 1'b1;
            ready_handshake_in <= 1'b0;
        end else if (wait_q < lag) begin
            // Slow answer: the destination is not ready yet
            wait_q <= wait_q + 4'h1;
        end else begin
            // Held until the bench drops the request, far beyond 1.5 cycles
            busy_handshake_in  <= 1'b0;
            ready_handshake_in <= 1'b1;
        end
    end
endmodule : csh_partner

//--- tb/test_csh_handshake.sv
// Self-checking bench of the clocked serial handshake block
`timescale 1ns/100ps
module test_csh_handshake;
    import csh_pkg::*;

    logic       ref_clk;
    logic       link_clk;
    logic       rst_n;
    logic       wr_sreg;
    logic [7:0] wr_data;
    logic       p_en;
    logic [3:0] p_lag;
    logic       busy_in;
    logic       ready_in;
    logic       xfer_flag;
    logic       xfer_irq;
    logic       prev_busy;
    logic       prev_clk_en;
    csh_cfg_t   cfg;
    csh_pins_t  pins;
    int         err_count;
    int         n_checks;
    int         n_clk;
    int         n_stb;
    int         n_rise;

    // ------------------------------------------------------------
    // Clocks and instances
    // ------------------------------------------------------------
    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;
    // Edges of the two clocks coincide every 12 ns
    initial link_clk = 1'b0;
    always #6 link_clk = ~link_clk;

    csh_handshake i_csh_handshake (
        .ref_clk            (ref_clk),
        .rst_n              (rst_n),
        .link_clk           (link_clk),
        .cfg                (cfg),
        .wr_sreg            (wr_sreg),
        .wr_data            (wr_data),
        .busy_handshake_in  (busy_in),
        .ready_handshake_in (ready_in),
        .xfer_flag          (xfer_flag),
        .xfer_irq           (xfer_irq),
        .pins               (pins)
    );

    csh_partner i_csh_partner (
        .link_clk           (link_clk),
        .rst_n              (rst_n),
        .en                 (p_en),
        .lag                (p_lag),
        .busy_handshake_in  (busy_in),
        .ready_handshake_in (ready_in)
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    // Pin watcher on the link clock; reads values from before each edge
    always @(posedge link_clk) begin
        if (rst_n === 1'b1) begin
            if (pins.serial_clock_pin_en === 1'b1) n_clk++;
            if (pins.transfer_end_strobe === 1'b1) n_stb++;
            if (pins.busy_handshake === 1'b1 && prev_busy === 1'b0) n_rise++;
            if (pins.serial_clock_pin_en === 1'b1 && prev_clk_en === 1'b0) begin
                chk("busy_lead", 16'h0000, {15'h0000, prev_busy});
            end
            chk("pin_inverse", {13'h0000, ~pins.transfer_end_strobe, ~pins.busy_handshake,
                ~pins.ready_handshake}, {13'h0000, pins.transfer_end_strobe_n,
                pins.busy_handshake_n, pins.ready_handshake_n});
        end
        prev_busy   <= pins.busy_handshake;
        prev_clk_en <= pins.serial_clock_pin_en;
    end

    // ------------------------------------------------------------
    // One transfer: write, stall the destination, release, finish
    // ------------------------------------------------------------
    task automatic xfer(input csh_mode_t mode, input logic int_clk, input logic whole,
        input logic rdy_used, input logic [7:0] data, input logic busy_pre,
        input int exp_clk, input int exp_stb, input int exp_rise, input logic drop_mid);
        int i;
        @(posedge ref_clk);
        cfg.mode          <= mode;
        cfg.int_clk       <= int_clk;
        cfg.func_whole    <= whole;
        cfg.ready_in_used <= rdy_used;
        repeat (8) @(posedge ref_clk);
        n_clk   = 0;
        n_stb   = 0;
        n_rise  = 0;
        wr_sreg <= 1'b1;
        wr_data <= data;
        @(posedge ref_clk);
        wr_sreg <= 1'b0;
        #1 chk("flag_set", 16'h0001, {15'h0000, xfer_flag});
        // Destination holds off: the transfer clock may not run yet
        repeat (20) @(posedge ref_clk);
        #1 chk("flag_hold", 16'h0001, {15'h0000, xfer_flag});
        chk("ready_up", 16'h0001, {15'h0000, pins.ready_handshake});
        chk("busy_pre", {15'h0000, busy_pre}, {15'h0000, pins.busy_handshake});
        chk("clk_pre", 16'h0000, n_clk[15:0]);
        if (cfg.sout_hiz) chk("oe_off", 16'h0001, {15'h0000, pins.serial_data_out_oe_n});
        @(posedge ref_clk);
        p_en <= 1'b1;
        if (drop_mid) begin
            for (i = 0; i < 200 && n_clk == 0; i++) @(posedge ref_clk);
            if (n_clk == 0) begin
                chk("clk_timeout", 16'h0001, 16'h0000);
                complete_run();
            end
            // Destination backs off in mid unit; the unit must still finish
            p_en <= 1'b0;
        end
        for (i = 0; i < 600; i++) begin
            @(posedge ref_clk);
            #1;
            if (xfer_irq === 1'b1) break;
        end
        if (i == 600) begin
            chk("irq_timeout", 16'h0001, 16'h0000);
            complete_run();
        end
        chk("flag_clear", 16'h0000, {15'h0000, xfer_flag});
        chk("busy_idle", 16'h0001, {15'h0000, pins.busy_handshake});
        chk("ready_low", 16'h0000, {15'h0000, pins.ready_handshake});
        chk("clk_count", exp_clk[15:0], n_clk[15:0]);
        chk("strobe_count", exp_stb[15:0], n_stb[15:0]);
        chk("busy_rises", exp_rise[15:0], n_rise[15:0]);
        if (cfg.sout_hiz) chk("oe_on", 16'h0000, {15'h0000, pins.serial_data_out_oe_n});
        @(posedge ref_clk);
        p_en         <= 1'b0;
        cfg.sout_hiz <= 1'b0;
    endtask : xfer

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n       = 1'b0;
        wr_sreg     = 1'b0;
        wr_data     = 8'h00;
        p_en        = 1'b0;
        p_lag       = 4'h0;
        err_count   = 0;
        n_checks    = 0;
        cfg         = '{init_en: 1'b1, int_clk: 1'b1, mode: CSH_MODE_8BIT, func_whole: 1'b0,
                        sout_hiz: 1'b1, busy_in_used: 1'b1, ready_in_used: 1'b1,
                        busy_out_used: 1'b1};
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1 chk("strobe_idle", 16'h0000, {15'h0000, pins.transfer_end_strobe});
        chk("busy_idle0", 16'h0001, {15'h0000, pins.busy_handshake});
        chk("ready_idle", 16'h0000, {15'h0000, pins.ready_handshake});
        xfer(CSH_MODE_8BIT, 1'b1, 1'b0, 1'b1, 8'h00, 1'b1, 8, 1, 1, 1'b0);
        p_lag <= 4'h5;
        xfer(CSH_MODE_ARB, 1'b1, 1'b0, 1'b1, 8'h04, 1'b1, 5, 1, 1, 1'b1);
        xfer(CSH_MODE_ARB, 1'b1, 1'b0, 1'b1, 8'h00, 1'b1, 1, 1, 1, 1'b0);
        p_lag <= 4'h0;
        xfer(CSH_MODE_AUTO, 1'b1, 1'b0, 1'b1, 8'h01, 1'b1, 16, 2, 2, 1'b0);
        xfer(CSH_MODE_AUTO, 1'b1, 1'b1, 1'b1, 8'h01, 1'b0, 16, 1, 1, 1'b0);
        xfer(CSH_MODE_8BIT, 1'b0, 1'b0, 1'b1, 8'h00, 1'b1, 0, 0, 1, 1'b0);
        xfer(CSH_MODE_8BIT, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 0, 0, 1, 1'b0);
        // Ready input used but busy output not: the ready level must be ignored
        @(posedge ref_clk);
        cfg.busy_out_used <= 1'b0;
        xfer(CSH_MODE_AUTO, 1'b0, 1'b1, 1'b1, 8'h00, 1'b0, 0, 0, 1, 1'b0);
        // Abort by the initialization bit in mid transfer
        cfg.int_clk <= 1'b1;
        cfg.mode    <= CSH_MODE_8BIT;
        repeat (8) @(posedge ref_clk);
        wr_sreg <= 1'b1;
        @(posedge ref_clk);
        wr_sreg <= 1'b0;
        p_en    <= 1'b1;
        repeat (12) @(posedge ref_clk);
        cfg.init_en <= 1'b0;
        repeat (12) @(posedge ref_clk);
        #1 chk("abort_flag", 16'h0000, {15'h0000, xfer_flag});
        chk("abort_strobe", 16'h0000, {15'h0000, pins.transfer_end_strobe});
        chk("abort_busy", 16'h0001, {15'h0000, pins.busy_handshake});
        chk("abort_ready", 16'h0000, {15'h0000, pins.ready_handshake});
        complete_run();
    end
endmodule : test_csh_handshake
